// file: jtr_pkg.sv
// Constants, codes and field layouts of the test access port
package jtr_pkg;

  // Register lengths
  localparam int unsigned IR_LEN  = 8;
  localparam int unsigned DR_LEN  = 32;
  localparam int unsigned BSC_LEN = 135;

  // Instruction codes
  localparam logic [7:0] INS_EXTEST   = 8'h00;
  localparam logic [7:0] INS_IDCODE   = 8'h21;
  localparam logic [7:0] INS_SAMPLE   = 8'h05;
  localparam logic [7:0] INS_CLAMP    = 8'h07;
  localparam logic [7:0] INS_HIGHZ    = 8'h03;
  localparam logic [7:0] INS_BYPASS   = 8'hff;
  localparam logic [7:0] INS_MIRROR01 = 8'h09;
  localparam logic [7:0] INS_MIRROR2  = 8'h0b;

  // Value loaded into the instruction shifter at capture
  localparam logic [7:0] IR_CAPTURE   = 8'h01;
  // Instruction after reset
  localparam logic [7:0] IR_RESET     = INS_IDCODE;

  // Identity register fields; maker and device values are arbitrary
  localparam logic [1:0]  ID_DIE_REV   = 2'h0;
  localparam logic [1:0]  ID_JK_CODE   = 2'h1;
  localparam logic        ID_SEP_IO    = 1'b0;
  localparam logic [2:0]  ID_DENSITY   = 3'h0;
  localparam logic [7:0]  ID_DEV_LOW   = 8'h5a;
  localparam logic [10:0] ID_MAKER     = 11'h155;
  localparam logic        PRESENCE_BIT = 1'b1;

  // Field positions
  localparam int unsigned ID_REV_MSB  = 31;
  localparam int unsigned ID_DEV_MSB  = 27;
  localparam int unsigned ID_MFR_MSB  = 11;
  localparam int unsigned MM_SEC_LSB  = 17;
  localparam int unsigned MM_RRC_POS  = 13;
  localparam int unsigned MM_FIRST_LSB = 1;

  // Reset values
  localparam logic [31:0] DR_RESET  = 32'h0000_0000;
  localparam logic        BIT_RESET = 1'b0;

  // Shortest legal test clock period and its length in system cycles
  localparam int unsigned TCK_MIN_PERIOD_NS = 20;
  localparam int unsigned REF_PERIOD_NS     = 8;
  localparam int unsigned TCK_MIN_CYCLES    =
    (TCK_MIN_PERIOD_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

  // Controller states, Gray steps along the shift paths
  typedef enum logic [3:0] {
    ST_TLR     = 4'h0,
    ST_RTI     = 4'h1,
    ST_SEL_DR  = 4'h3,
    ST_CAP_DR  = 4'h2,
    ST_SH_DR   = 4'h6,
    ST_EX1_DR  = 4'h7,
    ST_PAU_DR  = 4'h5,
    ST_EX2_DR  = 4'h4,
    ST_UPD_DR  = 4'hc,
    ST_SEL_IR  = 4'hd,
    ST_CAP_IR  = 4'hf,
    ST_SH_IR   = 4'he,
    ST_EX1_IR  = 4'ha,
    ST_PAU_IR  = 4'hb,
    ST_EX2_IR  = 4'h9,
    ST_UPD_IR  = 4'h8
  } jtr_state_t;

endpackage

// file: jtr_dr_if.sv
// Capture and shift controls of one scan register
`timescale 1ns/1ps
`default_nettype none
interface jtr_dr_if;
  logic capture;
  logic shift;
  logic ser_in;
  modport ctl  (output capture, output shift, output ser_in);
  modport sreg (input capture, input shift, input ser_in);
endinterface
`default_nettype wire

// file: jtr_scan_reg.sv
// Parallel-load serial scan register, exit end at bit 0
`timescale 1ns/1ps
`default_nettype none
module jtr_scan_reg #(
  parameter int unsigned W = 32
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Controls
  jtr_dr_if.sreg            ctl,
  // Data
  input  wire logic [W-1:0] par_in,
  output logic [W-1:0]      q
);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else if (ctl.capture)
    begin
      q <= par_in; // RULE21
    end
    else if (ctl.shift)
    begin
      q <= {ctl.ser_in, q[W-1:1]}; // RULE21
    end
  end

endmodule
`default_nettype wire

// file: jtr_tap_top.sv
// Test access port: instruction decode and data registers
//
// What this block does
// (RULE1) External-test captures the ring and selects the chain; memory outputs stay normal.
// (RULE2) Identification loads the fixed identity word and selects it.
// (RULE3) Sample/preload captures the ring into the chain and selects it.
// (RULE4) Clamp selects bypass and drives output balls from held chain values.
// (RULE5) High-impedance selects bypass and disables every ball output.
// (RULE6) All-ones selects bypass and leaves memory operation alone.
// (RULE7) Identity top nibble is revision; its low bits give the data width.
// (RULE8) Identity bits 27:12 hold device code with I/O bit and density.
// (RULE9) Identity bits 11:1 hold the maker code.
// (RULE10) Identity bit 0 reads one.
// (RULE11) Combined mirror bits 28:17 show the second mode register.
// (RULE12) Combined mirror bits 12:1 show the first mode register.
// (RULE13) Combined mirror bit 13 shows row repair capability.
// (RULE14) Combined mirror bits 31:29 and 16:14 read zero.
// (RULE15) Combined mirror bit 0 reads one.
// (RULE16) Third mirror shows its register in 10:1, one in bit 0.
// (RULE17) Chain has 135 cells numbered from the exit end.
// (RULE18) Test clock runs no faster than 50 MHz.
// (RULE19) Ring snapshot is taken on the test clock rising edge.
// (RULE20) Only defined instruction codes are loaded; the block loads any shifted code and treats undefined ones as bypass.
// (RULE21) Data registers load in parallel at capture, shift out LSB first.
// (RULE22) Mirrors have own codes and refresh at every capture.
`timescale 1ns/1ps
`default_nettype none
module jtr_tap_top #(
  parameter logic ORG_X36 = 1'b0
) (
  // System clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  // Serial test link
  input  wire logic                        tck,
  input  wire logic                        tms,
  input  wire logic                        tdi,
  output logic                             tdo,
  output logic                             tdo_oe,
  // Ball ring
  input  wire logic [jtr_pkg::BSC_LEN-1:0] ring_in,
  input  wire logic [jtr_pkg::BSC_LEN-1:0] core_out,
  input  wire logic [jtr_pkg::BSC_LEN-1:0] core_oe,
  output logic [jtr_pkg::BSC_LEN-1:0]      ball_out,
  output logic [jtr_pkg::BSC_LEN-1:0]      ball_oe,
  // Latched mode settings
  input  wire logic [11:0]                 first_mode_register,
  input  wire logic [11:0]                 second_mode_register,
  input  wire logic [9:0]                  third_mode_register,
  input  wire logic                        row_repair_capable
);

  localparam int unsigned N = jtr_pkg::BSC_LEN;

  logic             tck_meta;
  logic             tck_sync;
  logic             tck_prev;
  logic             tms_meta;
  logic             tms_sync;
  logic             tdi_meta;
  logic             tdi_sync;
  logic [N-1:0]     ring_meta;
  logic [N-1:0]     ring_sync;
  logic             tck_rise;
  logic             tck_fall;
  jtr_pkg::jtr_state_t state_reg;
  jtr_pkg::jtr_state_t state_next;
  logic [7:0]       ir_reg;
  logic [7:0]       ir_shift_reg;
  logic             bypass_reg;
  logic [N-1:0]     upd_reg;
  logic             tdo_reg;
  logic             tdo_oe_reg;
  logic [N-1:0]     ball_out_reg;
  logic [N-1:0]     ball_oe_reg;
  logic             sel_bsc;
  logic             sel_dr32;
  logic [31:0]      id_word;
  logic [31:0]      mirror01_word;
  logic [31:0]      mirror2_word;
  logic [31:0]      dr_par;
  logic [31:0]      dr_q;
  logic [N-1:0]     bsc_q;

  jtr_dr_if dr_if ();
  jtr_dr_if bsc_if ();

  // Two-flop synchronisers for everything arriving from the pins
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tck_meta  <= 1'b0;
      tck_sync  <= 1'b0;
      tck_prev  <= 1'b0;
      tms_meta  <= 1'b1;
      tms_sync  <= 1'b1;
      tdi_meta  <= 1'b0;
      tdi_sync  <= 1'b0;
      ring_meta <= '0;
      ring_sync <= '0;
    end
    else
    begin
      tck_meta  <= tck;
      tck_sync  <= tck_meta;
      tck_prev  <= tck_sync;
      tms_meta  <= tms;
      tms_sync  <= tms_meta;
      tdi_meta  <= tdi;
      tdi_sync  <= tdi_meta;
      ring_meta <= ring_in;
      ring_sync <= ring_meta;
    end
  end

  // Edges of the test clock; the 50 MHz ceiling leaves room for the sync delay
  assign tck_rise = tck_sync & ~tck_prev; // RULE18
  assign tck_fall = ~tck_sync & tck_prev;

  // Controller state walk
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      jtr_pkg::ST_TLR:    state_next = tms_sync ? jtr_pkg::ST_TLR    : jtr_pkg::ST_RTI;
      jtr_pkg::ST_RTI:    state_next = tms_sync ? jtr_pkg::ST_SEL_DR : jtr_pkg::ST_RTI;
      jtr_pkg::ST_SEL_DR: state_next = tms_sync ? jtr_pkg::ST_SEL_IR : jtr_pkg::ST_CAP_DR;
      jtr_pkg::ST_CAP_DR: state_next = tms_sync ? jtr_pkg::ST_EX1_DR : jtr_pkg::ST_SH_DR;
      jtr_pkg::ST_SH_DR:  state_next = tms_sync ? jtr_pkg::ST_EX1_DR : jtr_pkg::ST_SH_DR;
      jtr_pkg::ST_EX1_DR: state_next = tms_sync ? jtr_pkg::ST_UPD_DR : jtr_pkg::ST_PAU_DR;
      jtr_pkg::ST_PAU_DR: state_next = tms_sync ? jtr_pkg::ST_EX2_DR : jtr_pkg::ST_PAU_DR;
      jtr_pkg::ST_EX2_DR: state_next = tms_sync ? jtr_pkg::ST_UPD_DR : jtr_pkg::ST_SH_DR;
      jtr_pkg::ST_UPD_DR: state_next = tms_sync ? jtr_pkg::ST_SEL_DR : jtr_pkg::ST_RTI;
      jtr_pkg::ST_SEL_IR: state_next = tms_sync ? jtr_pkg::ST_TLR    : jtr_pkg::ST_CAP_IR;
      jtr_pkg::ST_CAP_IR: state_next = tms_sync ? jtr_pkg::ST_EX1_IR : jtr_pkg::ST_SH_IR;
      jtr_pkg::ST_SH_IR:  state_next = tms_sync ? jtr_pkg::ST_EX1_IR : jtr_pkg::ST_SH_IR;
      jtr_pkg::ST_EX1_IR: state_next = tms_sync ? jtr_pkg::ST_UPD_IR : jtr_pkg::ST_PAU_IR;
      jtr_pkg::ST_PAU_IR: state_next = tms_sync ? jtr_pkg::ST_EX2_IR : jtr_pkg::ST_PAU_IR;
      jtr_pkg::ST_EX2_IR: state_next = tms_sync ? jtr_pkg::ST_UPD_IR : jtr_pkg::ST_SH_IR;
      jtr_pkg::ST_UPD_IR: state_next = tms_sync ? jtr_pkg::ST_SEL_DR : jtr_pkg::ST_RTI;
      default:            state_next = jtr_pkg::ST_TLR;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= jtr_pkg::ST_TLR;
    end
    else if (tck_rise)
    begin
      state_reg <= state_next;
    end
  end

  // Instruction shifter and active instruction
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ir_shift_reg <= jtr_pkg::IR_CAPTURE;
    end
    else if (tck_rise && state_reg == jtr_pkg::ST_CAP_IR)
    begin
      ir_shift_reg <= jtr_pkg::IR_CAPTURE;
    end
    else if (tck_rise && state_reg == jtr_pkg::ST_SH_IR)
    begin
      ir_shift_reg <= {tdi_sync, ir_shift_reg[7:1]};
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ir_reg <= jtr_pkg::IR_RESET;
    end
    else if (state_reg == jtr_pkg::ST_TLR)
    begin
      ir_reg <= jtr_pkg::IR_RESET;
    end
    else if (tck_fall && state_reg == jtr_pkg::ST_UPD_IR)
    begin
      ir_reg <= ir_shift_reg;
    end
  end

  // Register selection; every code not listed falls back to bypass
  assign sel_bsc  = (ir_reg == jtr_pkg::INS_EXTEST) || (ir_reg == jtr_pkg::INS_SAMPLE); // RULE1 RULE3
  assign sel_dr32 = (ir_reg == jtr_pkg::INS_IDCODE) || // RULE2
                    (ir_reg == jtr_pkg::INS_MIRROR01) || (ir_reg == jtr_pkg::INS_MIRROR2); // RULE22 RULE20

  // Fixed identity word and mode mirrors
  assign id_word = {jtr_pkg::ID_DIE_REV, 1'b0, ORG_X36, // RULE7
                    2'b00, jtr_pkg::ID_JK_CODE, jtr_pkg::ID_SEP_IO, // RULE8
                    jtr_pkg::ID_DENSITY, jtr_pkg::ID_DEV_LOW, // RULE8
                    jtr_pkg::ID_MAKER, // RULE9
                    jtr_pkg::PRESENCE_BIT}; // RULE10
  assign mirror01_word = {3'b000, // RULE14
                          second_mode_register, // RULE11
                          3'b000, // RULE14
                          row_repair_capable, // RULE13
                          first_mode_register, // RULE12
                          jtr_pkg::PRESENCE_BIT}; // RULE15
  assign mirror2_word = {21'h00_0000, third_mode_register, jtr_pkg::PRESENCE_BIT}; // RULE16

  always_comb
  begin
    case (ir_reg)
      jtr_pkg::INS_MIRROR01: dr_par = mirror01_word; // RULE22
      jtr_pkg::INS_MIRROR2:  dr_par = mirror2_word; // RULE22
      default:               dr_par = id_word; // RULE2
    endcase
  end

  // Shared 32-bit data register
  assign dr_if.capture = tck_rise && (state_reg == jtr_pkg::ST_CAP_DR) && sel_dr32; // RULE21
  assign dr_if.shift   = tck_rise && (state_reg == jtr_pkg::ST_SH_DR) && sel_dr32;
  assign dr_if.ser_in  = tdi_sync;

  jtr_scan_reg #(.W(jtr_pkg::DR_LEN)) u_dr32 (
    .clk    (ref_clk),
    .rst    (sys_rst),
    .ctl    (dr_if.sreg),
    .par_in (dr_par),
    .q      (dr_q)
  );

  // Boundary chain, cell 1 at index 0 next to the serial output
  assign bsc_if.capture = tck_rise && (state_reg == jtr_pkg::ST_CAP_DR) && sel_bsc; // RULE19
  assign bsc_if.shift   = tck_rise && (state_reg == jtr_pkg::ST_SH_DR) && sel_bsc; // RULE17
  assign bsc_if.ser_in  = tdi_sync;

  jtr_scan_reg #(.W(N)) u_bsc (
    .clk    (ref_clk),
    .rst    (sys_rst),
    .ctl    (bsc_if.sreg),
    .par_in (ring_sync),
    .q      (bsc_q)
  );

  // Hold register for clamp values, loaded when the chain is updated
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      upd_reg <= '0;
    end
    else if (tck_fall && state_reg == jtr_pkg::ST_UPD_DR && sel_bsc)
    begin
      upd_reg <= bsc_q;
    end
  end

  // Bypass bit
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bypass_reg <= jtr_pkg::BIT_RESET;
    end
    else if (tck_rise && state_reg == jtr_pkg::ST_CAP_DR && !sel_bsc && !sel_dr32)
    begin
      bypass_reg <= 1'b0; // RULE4 RULE5 RULE6
    end
    else if (tck_rise && state_reg == jtr_pkg::ST_SH_DR && !sel_bsc && !sel_dr32)
    begin
      bypass_reg <= tdi_sync; // RULE6
    end
  end

  // Serial output changes on the falling test clock edge
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_oe_reg <= (state_reg == jtr_pkg::ST_SH_IR) || (state_reg == jtr_pkg::ST_SH_DR);
      tdo_reg    <= (state_reg == jtr_pkg::ST_SH_IR) ? ir_shift_reg[0] :
                    sel_bsc                          ? bsc_q[0]        :
                    sel_dr32                         ? dr_q[0]         : // RULE21
                    bypass_reg;
    end
  end

  // Ball drive: clamp holds chain values, high-Z releases, all else normal
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ball_out_reg <= '0;
      ball_oe_reg  <= '0;
    end
    else if (ir_reg == jtr_pkg::INS_CLAMP)
    begin
      ball_out_reg <= upd_reg; // RULE4
      ball_oe_reg  <= '1;
    end
    else if (ir_reg == jtr_pkg::INS_HIGHZ)
    begin
      ball_out_reg <= core_out;
      ball_oe_reg  <= '0; // RULE5
    end
    else
    begin
      ball_out_reg <= core_out; // RULE1 RULE2 RULE6
      ball_oe_reg  <= core_oe;
    end
  end

  assign tdo      = tdo_reg;
  assign tdo_oe   = tdo_oe_reg;
  assign ball_out = ball_out_reg;
  assign ball_oe  = ball_oe_reg;

  // Checks
  a_id_capture_word: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE2
    dr_if.capture && ir_reg == jtr_pkg::INS_IDCODE |=> dr_q == id_word)
    else $error("identity word not captured");
  a_id_fixed_bits: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE10
    dr_if.capture && ir_reg == jtr_pkg::INS_IDCODE |=>
      dr_q[0] && dr_q[11:1] == jtr_pkg::ID_MAKER && dr_q[28] == ORG_X36)
    else $error("identity fields wrong");
  a_mirror_layout: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE14
    dr_if.capture && ir_reg == jtr_pkg::INS_MIRROR01 |=>
      dr_q[31:29] == 3'b000 && dr_q[16:14] == 3'b000 && dr_q[0] &&
      dr_q[28:17] == $past(second_mode_register) && dr_q[12:1] == $past(first_mode_register) &&
      dr_q[13] == $past(row_repair_capable))
    else $error("combined mirror layout wrong");
  a_mirror2_layout: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE16
    dr_if.capture && ir_reg == jtr_pkg::INS_MIRROR2 |=>
      dr_q[10:1] == $past(third_mode_register) && dr_q[0])
    else $error("third mirror layout wrong");
  a_lsb_first_out: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE21
    tck_fall && state_reg == jtr_pkg::ST_SH_DR && sel_dr32 |=> tdo_reg == $past(dr_q[0]) && tdo_oe_reg)
    else $error("data register not shifted LSB first");
  a_ring_snapshot: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE19
    bsc_if.capture |-> tck_rise ##1 bsc_q == $past(ring_sync))
    else $error("ring snapshot not on rising edge");
  a_highz_release: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE5
    ir_reg == jtr_pkg::INS_HIGHZ |=> ball_oe_reg == '0)
    else $error("outputs not released under high-Z");
  a_clamp_drive: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE4
    ir_reg == jtr_pkg::INS_CLAMP |=> ball_out_reg == $past(upd_reg) && ball_oe_reg == '1)
    else $error("clamp not driving held values");
  a_normal_drive: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE1
    ir_reg != jtr_pkg::INS_CLAMP && ir_reg != jtr_pkg::INS_HIGHZ |=>
      ball_out_reg == $past(core_out) && ball_oe_reg == $past(core_oe))
    else $error("memory outputs disturbed");
  a_bypass_path: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE6
    tck_rise && state_reg == jtr_pkg::ST_SH_DR && ir_reg == jtr_pkg::INS_BYPASS |=>
      bypass_reg == $past(tdi_sync))
    else $error("bypass bit not in path");

endmodule
`default_nettype wire

// file: jtr_link_model.sv
// Test controller model that drives the serial test link
`timescale 1ns/1ps
`default_nettype none
module jtr_link_model (
  // Serial test link
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One test clock period of 125 ns; tdo is taken just before the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #62.5;
    // A released data out reads inverted, so a missing enable shows up
    q = tdo_oe ? tdo : ~tdo;
    tck = 1'b1;
    #62.5;
    tck = 1'b0;
  endtask

  // State moves; tdi toggles so an ignored line never looks settled
  task automatic walk(input logic [5:0] seq, input int n);
    logic q;
    for (int i = 0; i < n; i++)
      step(seq[i], ~tdi, q);
  endtask

  // Five rises with tms high, then on to run-test/idle
  task automatic reset_tap();
    walk(6'b01_1111, 6);
  endtask

  // Only the defined codes are ever handed in here
  task automatic shift_ir(input logic [7:0] code, output logic [7:0] cap);
    walk(6'b00_0011, 4);
    for (int i = 0; i < 8; i++)
      step(i == 7, code[i], cap[i]);
    walk(6'b00_0001, 2);
  endtask

  task automatic shift_dr(input int n, input logic [134:0] din, output logic [134:0] dout);
    dout = '0;
    walk(6'b00_0001, 3);
    for (int i = 0; i < n; i++)
      step(i == n - 1, din[i], dout[i]);
    walk(6'b00_0001, 2);
  endtask
endmodule
`default_nettype wire

// file: jtr_tap_top_test.sv
// Self-checking testbench of the test access port
`timescale 1ns/1ps
`default_nettype none
module jtr_tap_top_test;
  localparam logic ORG = 1'b1;
  logic         ref_clk;
  logic         sys_rst;
  logic         tck;
  logic         tms;
  logic         tdi;
  logic         tdo;
  logic         tdo_oe;
  logic         rrc;
  logic [134:0] ring_in;
  logic [134:0] core_out;
  logic [134:0] core_oe;
  logic [134:0] ball_out;
  logic [134:0] ball_oe;
  logic [11:0]  mr_first;
  logic [11:0]  mr_second;
  logic [9:0]   mr_third;
  logic [7:0]   cap;
  logic [134:0] dout;
  int           mismatches;
  int           num_checks;

  jtr_tap_top #(.ORG_X36(ORG)) u_dut (
    .ref_clk              (ref_clk),
    .sys_rst              (sys_rst),
    .tck                  (tck),
    .tms                  (tms),
    .tdi                  (tdi),
    .tdo                  (tdo),
    .tdo_oe               (tdo_oe),
    .ring_in              (ring_in),
    .core_out             (core_out),
    .core_oe              (core_oe),
    .ball_out             (ball_out),
    .ball_oe              (ball_oe),
    .first_mode_register  (mr_first),
    .second_mode_register (mr_second),
    .third_mode_register  (mr_third),
    .row_repair_capable   (rrc)
  );

  jtr_link_model u_link (
    .tck (tck),
    .tms (tms),
    .tdi (tdi),
    .tdo    (tdo),
    .tdo_oe (tdo_oe)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    if (mismatches == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [134:0] got, input logic [134:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic t_identity();
    logic [31:0] id_exp;
    id_exp = {jtr_pkg::ID_DIE_REV, 1'b0, ORG, 2'b00, jtr_pkg::ID_JK_CODE, jtr_pkg::ID_SEP_IO,
              jtr_pkg::ID_DENSITY, jtr_pkg::ID_DEV_LOW, jtr_pkg::ID_MAKER, 1'b1};
    u_link.reset_tap();
    u_link.shift_dr(32, '1, dout);
    chk(dout, {103'h0, id_exp}, "identity after reset");
    u_link.shift_ir(jtr_pkg::INS_IDCODE, cap);
    chk({127'h0, cap}, {127'h0, jtr_pkg::IR_CAPTURE}, "instruction capture");
    u_link.shift_dr(32, '0, dout);
    chk(dout, {103'h0, id_exp}, "identity word");
    chk(ball_oe, core_oe, "enables under identify");
    chk({134'h0, tdo_oe}, '0, "enable outside shift");
  endtask

  // Two settings of the mode registers, each captured afresh
  task automatic t_mirrors();
    for (int k = 0; k < 2; k++)
    begin
      @(posedge ref_clk);
      #1;
      mr_first = k ? 12'h0a5c : 12'h03f1;
      mr_second = k ? 12'h0c36 : 12'h0e09;
      mr_third = k ? 10'h2d3 : 10'h14c;
      rrc = k[0];
      u_link.shift_ir(jtr_pkg::INS_MIRROR01, cap);
      u_link.shift_dr(32, '1, dout);
      chk(dout, {103'h0, 3'b000, mr_second, 3'b000, rrc, mr_first, 1'b1},
          "combined mirror");
      u_link.shift_ir(jtr_pkg::INS_MIRROR2, cap);
      u_link.shift_dr(32, '1, dout);
      chk(dout, {103'h0, 21'h0, mr_third, 1'b1}, "third mirror");
    end
  endtask

  // Bypass path: captured zero leads, then the first bit shifted in
  task automatic t_bypass();
    logic [7:0] codes [3];
    codes = '{jtr_pkg::INS_BYPASS, jtr_pkg::INS_CLAMP, jtr_pkg::INS_HIGHZ};
    for (int k = 0; k < 3; k++)
    begin
      u_link.shift_ir(codes[k], cap);
      u_link.shift_dr(2, 135'h3, dout);
      chk(dout, 135'h2, "one-bit path");
    end
    u_link.shift_ir(jtr_pkg::INS_BYPASS, cap);
    chk(ball_out, core_out, "values under bypass");
    chk(ball_oe, core_oe, "enables under bypass");
  endtask

  task automatic t_chain();
    logic [134:0] pat;
    logic [134:0] load;
    pat = {5{27'h5a3_c96f}};
    load = {5{27'h2c6_1e93}};
    @(posedge ref_clk);
    #1;
    ring_in = pat;
    u_link.shift_ir(jtr_pkg::INS_SAMPLE, cap);
    u_link.shift_dr(135, load, dout);
    chk(dout, pat, "sampled ring");
    u_link.shift_ir(jtr_pkg::INS_CLAMP, cap);
    chk(ball_out, load, "clamped values");
    chk(ball_oe, '1, "clamped enables");
    @(posedge ref_clk);
    #1;
    ring_in = ~pat;
    u_link.shift_ir(jtr_pkg::INS_EXTEST, cap);
    chk(ball_out, core_out, "values under external test");
    chk(ball_oe, core_oe, "enables under external test");
    u_link.shift_dr(135, pat, dout);
    chk(dout, ~pat, "ring under external test");
    u_link.shift_ir(jtr_pkg::INS_HIGHZ, cap);
    chk(ball_oe, '0, "enables under high impedance");
  endtask

  initial
  begin
    mismatches = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    rrc = 1'b0;
    mr_first = 12'h000;
    mr_second = 12'h000;
    mr_third = 10'h000;
    ring_in = '0;
    core_out = {5{27'h71d_2b48}};
    core_oe = {5{27'h0f0_f0f0}};
    repeat (5) @(posedge ref_clk);
    chk({134'h0, tdo_oe}, '0, "enable in reset");
    chk(ball_oe, '0, "ball enables in reset");
    #1;
    sys_rst = 1'b0;
    repeat (3) @(posedge ref_clk);
    chk(ball_out, core_out, "values after reset");
    t_identity();
    t_mirrors();
    t_bypass();
    t_chain();
    summarize();
  end

  // Cuts a hang short
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    mismatches++;
    $display("wrong value at %0t: run did not finish", $time);
    summarize();
  end
endmodule
`default_nettype wire
